// *** core/sgs_pkg.sv ***
// Constants and carrier types for the servo gain switch and resonance control.
package sgs_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_FREQ_HZ = 100_000_000;

	// One step of a switching delay setting, in microseconds.
	localparam int DELAY_UNIT_US = 100;
	localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_US * 1000 / CLK_PERIOD_NS;

	// Command variation is measured over this window.
	localparam int RATE_WINDOW_MS = 1000;
	localparam int RATE_WINDOW_CYCLES = RATE_WINDOW_MS * (CLK_FREQ_HZ / 1000);

	// One level step of the speed-rate condition is 10 r/min per second.
	localparam logic [19:0] SPEED_RATE_STEP = 20'h0000A;

	localparam logic [2:0] VSEL_FIRST = 3'h0;
	localparam logic [2:0] VSEL_SECOND = 3'h1;
	localparam logic [2:0] VSEL_SWITCH_IN = 3'h2;
	localparam logic [2:0] VSEL_TORQUE = 3'h3;
	localparam logic [2:0] VSEL_SPEED_RATE = 3'h4;
	localparam logic [2:0] VSEL_SPEED = 3'h5;

	localparam logic [1:0] TSEL_FIRST = 2'h0;
	localparam logic [1:0] TSEL_SECOND = 2'h1;
	localparam logic [1:0] TSEL_SWITCH_IN = 2'h2;
	localparam logic [1:0] TSEL_TORQUE_RATE = 2'h3;

	localparam logic [1:0] ADAPT_OFF = 2'h0;
	localparam logic [1:0] ADAPT_TWO = 2'h2;

	localparam logic [15:0] NOTCH_OFF_FREQ = 16'h1388;

	// Filter time constant step is 10 us; cutoff is this number over it.
	localparam real PI = 3.14159265358979;
	localparam real TC_UNIT_S = 0.00001;
	localparam logic [31:0] CUTOFF_NUM = 32'($rtoi(1.0 / (2.0 * PI * TC_UNIT_S)));
	localparam logic [15:0] CUTOFF_MAX = 16'hFFFF;

	typedef enum logic {SGS_MODE_VELOCITY, SGS_MODE_TORQUE} sgs_mode_t;

	typedef enum {GAIN_FIRST, GAIN_SECOND, GAIN_RETURN} sgs_gain_state_t;

	typedef struct packed {
		logic [15:0] delay;
		logic [15:0] level;
		logic [15:0] hysteresis;
	} sgs_switch_cfg_t;

	typedef struct packed {
		logic [15:0] freq;
		logic [7:0] width;
		logic [7:0] depth;
	} sgs_notch_t;

	typedef struct packed {
		logic res1Found;
		logic [15:0] res1Freq;
		logic res2Found;
		logic [15:0] res2Freq;
		logic [7:0] width3;
		logic [7:0] depth3;
		logic [7:0] width4;
		logic [7:0] depth4;
	} sgs_estimate_t;

	localparam sgs_notch_t NOTCH_RESET = '{freq: NOTCH_OFF_FREQ,
		width: 8'h00, depth: 8'h00};

endpackage : sgs_pkg

// *** core/sgs_gain_switch.sv ***
// Gain set selection, torque filter and adaptive notch control.
//
// Function
// - Velocity codes 0,1,2: first, second, pin.
// - Velocity code 4: speed command rate, no delay.
// - Codes 3, 5: torque, speed, with delay.
// - Torque code 3: torque change, with delay.
// - Torque code 2 follows gain switch pin.
// - Each mode uses its own switch settings.
// - Delay applies only returning to first gain.
// - Rate level step equals 10 r/min/s.
// - Cutoff is one over 2 pi tc 10us.
// - Nonzero adaptive mode enables adaptive filtering.
// - Adaptive estimates write third/fourth notch settings.
// - No resonance found gives notch frequency 5000.
// - Fourth notch takes second resonance frequency.
// - Third notch width, depth auto when adaptive.
// - Fourth notch width auto with two filters.
// - Notch frequency 5000 disables that notch.
`timescale 1ns/1ps
module sgs_gain_switch #(
	parameter int DELAY_UNIT_CYCLES = sgs_pkg::DELAY_UNIT_CYCLES,
	parameter int RATE_WINDOW_CYCLES = sgs_pkg::RATE_WINDOW_CYCLES
) (
	input logic clk,
	input logic rst,
	input sgs_pkg::sgs_mode_t controlMode,
	input logic [2:0] velocityGainSelectCode,
	input logic [1:0] torqueGainSelectCode,
	input sgs_pkg::sgs_switch_cfg_t velocitySwitch,
	input sgs_pkg::sgs_switch_cfg_t torqueSwitch,
	input logic gainSwitchPin,
	input logic signed [15:0] speedCmd,
	input logic signed [15:0] torqueCmd,
	input logic [15:0] torqueFilterTcFirst,
	input logic [15:0] torqueFilterTcSecond,
	input logic [1:0] adaptiveFilterMode,
	input sgs_pkg::sgs_notch_t manualNotch3,
	input sgs_pkg::sgs_notch_t manualNotch4,
	input logic estimateValid,
	input sgs_pkg::sgs_estimate_t estimate,
	output logic gainSecond,
	output logic [15:0] torqueFilterTc,
	output logic [15:0] torqueFilterCutoff,
	output sgs_pkg::sgs_notch_t notch3,
	output sgs_pkg::sgs_notch_t notch4,
	output logic notch3Enable,
	output logic notch4Enable
);

	logic gainSwMeta_r;
	logic gainSwSync_r;
	logic [31:0] winCnt_r;
	logic winTick;
	logic signed [15:0] prevSpeed_r;
	logic signed [15:0] prevTorque_r;
	logic [16:0] speedRate_r;
	logic [16:0] torqueRate_r;
	logic [16:0] speedAbs;
	logic [16:0] torqueAbs;
	sgs_pkg::sgs_switch_cfg_t cfg;
	logic [19:0] monValue;
	logic [19:0] monLevel;
	logic [19:0] monHyst;
	logic levelMode;
	logic usesDelay;
	logic levelHit;
	logic want2nd;
	logic condAbove_r;
	sgs_pkg::sgs_gain_state_t state_r;
	logic [31:0] preCnt_r;
	logic [15:0] unitCnt_r;
	logic delayDone;
	logic [15:0] tcSel;
	logic [15:0] torqueFilterTc_r;
	logic [15:0] torqueFilterCutoff_r;
	logic adaptOn;
	logic twoFilters;
	sgs_pkg::sgs_notch_t notch3_r;
	sgs_pkg::sgs_notch_t notch4_r;

	function automatic logic [16:0] absDiff(
		input logic signed [15:0] a,
		input logic signed [15:0] b
	);
		logic signed [16:0] d;
		d = {a[15], a} - {b[15], b};
		return d[16] ? 17'(-d) : 17'(d);
	endfunction : absDiff

	// Compares with the current decision as memory, so a value inside the
	// hysteresis band keeps whatever was decided last.
	function automatic logic hystCompare(
		input logic above,
		input logic [19:0] value,
		input logic [19:0] lvl,
		input logic [19:0] hy
	);
		logic signed [21:0] v;
		logic signed [21:0] onTh;
		logic signed [21:0] offTh;
		v = {2'b00, value};
		onTh = {2'b00, lvl} + {3'b000, hy[19:1]};
		offTh = {2'b00, lvl} - {3'b000, hy[19:1]};
		return above ? !(v < offTh) : (v > onTh);
	endfunction : hystCompare

	// The gain switch pin is asynchronous to the control cycle.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			gainSwMeta_r <= 1'b0;
			gainSwSync_r <= 1'b0;
		end
		else
		begin
			gainSwMeta_r <= gainSwitchPin;
			gainSwSync_r <= gainSwMeta_r;
		end
	end

	assign winTick = (winCnt_r == 32'(RATE_WINDOW_CYCLES - 1));

	always_ff @(posedge clk)
	begin
		if (rst)
			winCnt_r <= 32'h0;
		else if (winTick)
			winCnt_r <= 32'h0;
		else
			winCnt_r <= winCnt_r + 32'h1;
	end

	// Variation is the command change across one window; it is held
	// between window ends, so it reacts at most one window late.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prevSpeed_r <= 16'sh0000;
			prevTorque_r <= 16'sh0000;
			speedRate_r <= 17'h00000;
			torqueRate_r <= 17'h00000;
		end
		else if (winTick)
		begin
			prevSpeed_r <= speedCmd;
			prevTorque_r <= torqueCmd;
			speedRate_r <= absDiff(speedCmd, prevSpeed_r);
			torqueRate_r <= absDiff(torqueCmd, prevTorque_r);
		end
	end

	assign speedAbs = absDiff(speedCmd, 16'sh0000);
	assign torqueAbs = absDiff(torqueCmd, 16'sh0000);

	always_comb
	begin
		cfg = (controlMode == sgs_pkg::SGS_MODE_VELOCITY) ?
			velocitySwitch : torqueSwitch;
		monValue = 20'h00000;
		monLevel = {4'h0, cfg.level};
		monHyst = {4'h0, cfg.hysteresis};
		levelMode = 1'b0;
		usesDelay = 1'b0;
		want2nd = 1'b0;
		if (controlMode == sgs_pkg::SGS_MODE_VELOCITY)
		begin
			unique case (velocityGainSelectCode)
				sgs_pkg::VSEL_FIRST: want2nd = 1'b0;
				sgs_pkg::VSEL_SECOND: want2nd = 1'b1;
				sgs_pkg::VSEL_SWITCH_IN: want2nd = gainSwSync_r;
				sgs_pkg::VSEL_TORQUE:
				begin
					monValue = {3'h0, torqueAbs};
					levelMode = 1'b1;
					usesDelay = 1'b1;
				end
				sgs_pkg::VSEL_SPEED_RATE:
				begin
					monValue = {3'h0, speedRate_r};
					monLevel = 20'({4'h0, cfg.level} *
						sgs_pkg::SPEED_RATE_STEP);
					monHyst = 20'({4'h0, cfg.hysteresis} *
						sgs_pkg::SPEED_RATE_STEP);
					levelMode = 1'b1;
				end
				sgs_pkg::VSEL_SPEED:
				begin
					monValue = {3'h0, speedAbs};
					levelMode = 1'b1;
					usesDelay = 1'b1;
				end
				default: want2nd = 1'b0;
			endcase
		end
		else
		begin
			unique case (torqueGainSelectCode)
				sgs_pkg::TSEL_FIRST: want2nd = 1'b0;
				sgs_pkg::TSEL_SECOND: want2nd = 1'b1;
				sgs_pkg::TSEL_SWITCH_IN: want2nd = gainSwSync_r;
				sgs_pkg::TSEL_TORQUE_RATE:
				begin
					monValue = {3'h0, torqueRate_r};
					levelMode = 1'b1;
					usesDelay = 1'b1;
				end
			endcase
		end
		levelHit = hystCompare(condAbove_r, monValue, monLevel,
			monHyst);
		if (levelMode)
			want2nd = levelHit;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			condAbove_r <= 1'b0;
		else
			condAbove_r <= levelMode & levelHit;
	end

	assign delayDone = (unitCnt_r >= cfg.delay);

	// Rising to the second gain never waits; only the return is delayed.
	always_ff @(posedge clk)
	begin
		if (rst)
			state_r <= sgs_pkg::GAIN_FIRST;
		else
		begin
			unique case (state_r)
				sgs_pkg::GAIN_FIRST:
					if (want2nd)
						state_r <= sgs_pkg::GAIN_SECOND;
				sgs_pkg::GAIN_SECOND:
					if (!want2nd)
						state_r <= (usesDelay && cfg.delay != 16'h0000) ?
							sgs_pkg::GAIN_RETURN : sgs_pkg::GAIN_FIRST;
				sgs_pkg::GAIN_RETURN:
					if (want2nd)
						state_r <= sgs_pkg::GAIN_SECOND;
					else if (!usesDelay || delayDone)
						state_r <= sgs_pkg::GAIN_FIRST;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst || state_r != sgs_pkg::GAIN_RETURN || want2nd)
		begin
			preCnt_r <= 32'h0;
			unitCnt_r <= 16'h0000;
		end
		else if (preCnt_r == 32'(DELAY_UNIT_CYCLES - 1))
		begin
			preCnt_r <= 32'h0;
			if (unitCnt_r != 16'hFFFF)
				unitCnt_r <= unitCnt_r + 16'h0001;
		end
		else
			preCnt_r <= preCnt_r + 32'h1;
	end

	assign gainSecond = (state_r != sgs_pkg::GAIN_FIRST);

	assign tcSel = gainSecond ? torqueFilterTcSecond : torqueFilterTcFirst;

	// A zero time constant means no filtering, shown as the top cutoff.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			torqueFilterTc_r <= 16'h0000;
			torqueFilterCutoff_r <= sgs_pkg::CUTOFF_MAX;
		end
		else
		begin
			torqueFilterTc_r <= tcSel;
			torqueFilterCutoff_r <= (tcSel == 16'h0000) ?
				sgs_pkg::CUTOFF_MAX :
				16'(sgs_pkg::CUTOFF_NUM / {16'h0000, tcSel});
		end
	end

	assign torqueFilterTc = torqueFilterTc_r;
	assign torqueFilterCutoff = torqueFilterCutoff_r;

	assign adaptOn = (adaptiveFilterMode != sgs_pkg::ADAPT_OFF);
	assign twoFilters = (adaptiveFilterMode >= sgs_pkg::ADAPT_TWO);

	always_ff @(posedge clk)
	begin
		if (rst)
			notch3_r <= sgs_pkg::NOTCH_RESET;
		else if (!adaptOn)
			notch3_r <= manualNotch3;
		else if (estimateValid)
		begin
			notch3_r.freq <= estimate.res1Found ? estimate.res1Freq :
				sgs_pkg::NOTCH_OFF_FREQ;
			notch3_r.width <= estimate.width3;
			notch3_r.depth <= estimate.depth3;
		end
	end

	// With a single adaptive filter the fourth notch stays under host control.
	always_ff @(posedge clk)
	begin
		if (rst)
			notch4_r <= sgs_pkg::NOTCH_RESET;
		else if (!twoFilters)
			notch4_r <= manualNotch4;
		else if (estimateValid)
		begin
			notch4_r.freq <= estimate.res2Found ? estimate.res2Freq :
				sgs_pkg::NOTCH_OFF_FREQ;
			notch4_r.width <= estimate.width4;
			notch4_r.depth <= estimate.depth4;
		end
	end

	assign notch3 = notch3_r;
	assign notch4 = notch4_r;
	assign notch3Enable = (notch3_r.freq != sgs_pkg::NOTCH_OFF_FREQ);
	assign notch4Enable = (notch4_r.freq != sgs_pkg::NOTCH_OFF_FREQ);

	a_vel_fixed_gain: assert property (@(posedge clk) disable iff (rst)
		(controlMode == sgs_pkg::SGS_MODE_VELOCITY &&
		velocityGainSelectCode == sgs_pkg::VSEL_SECOND) [*2]
		|-> gainSecond)
		else $error("velocity code 1 did not select second gain");

	a_torque_pin_follow: assert property (@(posedge clk) disable iff (rst)
		(controlMode == sgs_pkg::SGS_MODE_TORQUE &&
		torqueGainSelectCode == sgs_pkg::TSEL_SWITCH_IN) [*2]
		|-> gainSecond == $past(gainSwSync_r))
		else $error("torque code 2 gain does not follow the pin");

	a_rise_no_delay: assert property (@(posedge clk) disable iff (rst)
		(!gainSecond && want2nd) |=> gainSecond)
		else $error("switch to second gain was delayed");

	a_return_delayed: assert property (@(posedge clk) disable iff (rst)
		(state_r == sgs_pkg::GAIN_SECOND && !want2nd && usesDelay &&
		cfg.delay != 16'h0000) |=> gainSecond [*2])
		else $error("return to first gain ignored the delay");

	a_speed_level_on: assert property (@(posedge clk) disable iff (rst)
		(controlMode == sgs_pkg::SGS_MODE_VELOCITY &&
		velocityGainSelectCode == sgs_pkg::VSEL_SPEED &&
		{3'h0, speedAbs} > {4'h0, cfg.level} + {5'h00, cfg.hysteresis[15:1]})
		|=> gainSecond)
		else $error("speed above level did not raise second gain");

	a_cutoff_value: assert property (@(posedge clk) disable iff (rst)
		(tcSel != 16'h0000) |=> torqueFilterCutoff ==
		16'(sgs_pkg::CUTOFF_NUM / {16'h0000, $past(tcSel)}))
		else $error("torque filter cutoff is wrong");

	a_notch3_none: assert property (@(posedge clk) disable iff (rst)
		(adaptOn && estimateValid && !estimate.res1Found)
		|=> notch3.freq == sgs_pkg::NOTCH_OFF_FREQ && !notch3Enable)
		else $error("third notch not disabled without resonance");

	a_notch4_load: assert property (@(posedge clk) disable iff (rst)
		(twoFilters && estimateValid && estimate.res2Found)
		|=> notch4.freq == $past(estimate.res2Freq) && notch4Enable ==
		($past(estimate.res2Freq) != sgs_pkg::NOTCH_OFF_FREQ))
		else $error("fourth notch did not take second resonance");

	a_notch4_manual: assert property (@(posedge clk) disable iff (rst)
		(!twoFilters) |=> notch4.width == $past(manualNotch4.width))
		else $error("fourth notch width changed without two filters");

	a_notch3_width: assert property (@(posedge clk) disable iff (rst)
		(adaptOn && estimateValid) |=> notch3.width == $past(estimate.width3)
		&& notch3.depth == $past(estimate.depth3))
		else $error("third notch width or depth not updated");

endmodule : sgs_gain_switch

// *** verification/sgs_host_model.sv ***
// Host controller model that drives the speed, torque and gain switch inputs.
`timescale 1ns/1ps
module sgs_host_model (
	input logic clk,
	output logic signed [15:0] speedCmd,
	output logic signed [15:0] torqueCmd,
	output logic gainSwitchPin
);
	initial
	begin
		speedCmd = 16'sh0000;
		torqueCmd = 16'sh0000;
		gainSwitchPin = 1'b0;
	end

	// A real host refreshes its commands once per control cycle, so the
	// model changes all three together just after a rising edge.
	task automatic drive(input logic signed [15:0] s,
		input logic signed [15:0] t, input logic p);
		@(posedge clk);
		speedCmd <= s;
		torqueCmd <= t;
		gainSwitchPin <= p;
	endtask : drive
endmodule : sgs_host_model

// *** verification/test_sgs_gain_switch.sv ***
// Self-checking testbench for the gain switch and resonance control block.
`timescale 1ns/1ps
module test_sgs_gain_switch;
	typedef struct {int id; logic [31:0] v; int cyc; bit hold;} sgs_note_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	sgs_pkg::sgs_mode_t mode = sgs_pkg::SGS_MODE_VELOCITY;
	logic [2:0] vCode = 3'h0;
	logic [1:0] tCode = 2'h0;
	sgs_pkg::sgs_switch_cfg_t vSw = '0;
	sgs_pkg::sgs_switch_cfg_t tSw = '0;
	logic [15:0] tcFirst = 16'h0064;
	logic [15:0] tcSecond = 16'h0041;
	logic [1:0] aMode = 2'h0;
	sgs_pkg::sgs_notch_t man3 = '{16'h07D0, 8'h03, 8'h05};
	sgs_pkg::sgs_notch_t man4 = '{16'h0BB8, 8'h02, 8'h07};
	logic estValid = 1'b0;
	sgs_pkg::sgs_estimate_t est = '0;
	sgs_pkg::sgs_estimate_t lastEst;
	logic gainSecond, en3, en4, pin;
	logic [15:0] tc, cutoff;
	logic signed [15:0] speedCmd, torqueCmd;
	sgs_pkg::sgs_notch_t notch3, notch4;
	logic [31:0] seed = 32'h0D885D84;
	int failCount = 0;
	int nChecks = 0;
	sgs_note_t notes[$];
	string names[6] = '{"gain", "tc", "cutoff", "notch3", "notch4", "enables"};

	always #5 clk = ~clk;

	sgs_host_model host (.clk(clk), .speedCmd(speedCmd),
		.torqueCmd(torqueCmd), .gainSwitchPin(pin));

	sgs_gain_switch #(.DELAY_UNIT_CYCLES(4), .RATE_WINDOW_CYCLES(16)) dut (
		.clk(clk), .rst(rst), .controlMode(mode),
		.velocityGainSelectCode(vCode), .torqueGainSelectCode(tCode),
		.velocitySwitch(vSw), .torqueSwitch(tSw), .gainSwitchPin(pin),
		.speedCmd(speedCmd), .torqueCmd(torqueCmd),
		.torqueFilterTcFirst(tcFirst), .torqueFilterTcSecond(tcSecond),
		.adaptiveFilterMode(aMode), .manualNotch3(man3),
		.manualNotch4(man4), .estimateValid(estValid), .estimate(est),
		.gainSecond(gainSecond), .torqueFilterTc(tc),
		.torqueFilterCutoff(cutoff), .notch3(notch3), .notch4(notch4),
		.notch3Enable(en3), .notch4Enable(en4));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [31:0] obs(input int id);
		case (id)
			0: return {31'h0, gainSecond};
			1: return {16'h0, tc};
			2: return {16'h0, cutoff};
			3: return notch3;
			4: return notch4;
			default: return {30'h0, en3, en4};
		endcase
	endfunction : obs

	function automatic logic [31:0] cut(input logic [15:0] t);
		return sgs_pkg::CUTOFF_NUM / {16'h0, t};
	endfunction : cut

	function automatic logic [15:0] nf(input logic f, input logic [15:0] q);
		return f ? q : sgs_pkg::NOTCH_OFF_FREQ;
	endfunction : nf

	task automatic cmpBit(input string n, input logic e, input logic s);
		nChecks++;
		if (e !== s)
		begin
			failCount++;
			$display("mismatch %s expected %b seen %b", n, e, s);
		end
	endtask : cmpBit

	task automatic cmpWord(input string n, input logic [31:0] e,
		input logic [31:0] s);
		nChecks++;
		if (e !== s)
		begin
			failCount++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : cmpWord

	// A hold note demands the value on every cycle of its span; any other
	// note accepts the first cycle within the span that shows it.
	initial
	begin
		sgs_note_t n;
		logic [31:0] s;
		forever
		begin
			wait (notes.size() > 0);
			n = notes[0];
			for (int k = 0; k < n.cyc; k++)
			begin
				@(negedge clk);
				s = obs(n.id);
				if ((s === n.v) != n.hold)
					break;
			end
			if (n.id == 0)
				cmpBit(names[0], n.v[0], s[0]);
			else
				cmpWord(names[n.id], n.v, s);
			void'(notes.pop_front());
		end
	end

	task automatic chk(input int id, input logic [31:0] v, input int cyc,
		input bit hold);
		notes.push_back('{id, v, cyc, hold});
		wait (notes.size() == 0);
		// The checker returns at a falling edge; new stimulus waits for the
		// next rising edge so that inputs only ever change on it.
		@(posedge clk);
	endtask : chk

	task automatic pulse(input logic f1, input logic f2);
		logic [31:0] r;
		logic [31:0] w;
		r = xs();
		w = xs();
		lastEst = '{f1, {4'h0, r[11:0]}, f2, {4'h0, r[27:16]},
			w[7:0], w[15:8], w[23:16], w[31:24]};
		@(posedge clk);
		est <= lastEst;
		estValid <= 1'b1;
		@(posedge clk);
		estValid <= 1'b0;
	endtask : pulse

	task automatic endOfTest();
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : endOfTest

	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		failCount++;
		endOfTest();
	end

	initial
	begin
		repeat (2) @(posedge clk);
		chk(2, 32'h0000FFFF, 2, 0);
		chk(4, sgs_pkg::NOTCH_RESET, 2, 0);
		chk(5, 32'h0, 2, 0);
		wait (!rst);
		$display("test reset done");
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge clk);
			vCode <= 3'(i);
			tcFirst <= 16'(xs() | 32'h1);
			chk(0, {31'h0, i == 1}, 6, i > 1);
			if (i < 2)
				chk(1, i ? tcSecond : tcFirst, 4, 0);
			if (i < 2)
				chk(2, cut(i ? tcSecond : tcFirst), 4, 0);
		end
		vCode <= 3'h2;
		host.drive(0, 0, 1);
		chk(0, 1, 5, 0);
		host.drive(0, 0, 0);
		chk(0, 0, 5, 0);
		mode <= sgs_pkg::SGS_MODE_TORQUE;
		tCode <= 2'h1;
		chk(0, 1, 5, 0);
		tCode <= 2'h0;
		chk(0, 0, 5, 0);
		tCode <= 2'h2;
		host.drive(0, 0, 1);
		chk(0, 1, 5, 0);
		host.drive(0, 0, 0);
		chk(0, 0, 5, 0);
		$display("test fixed codes done");
		vSw <= '{16'h0000, 16'h0FFF, 16'h0000};
		tSw <= '{16'h0000, 16'h0032, 16'h0000};
		tCode <= 2'h3;
		host.drive(0, 100, 0);
		chk(0, 1, 40, 0);
		chk(0, 0, 40, 0);
		mode <= sgs_pkg::SGS_MODE_VELOCITY;
		vSw <= '{16'h0000, 16'h0032, 16'h0000};
		vCode <= 3'h3;
		chk(0, 1, 4, 0);
		host.drive(0, 0, 0);
		chk(0, 0, 6, 0);
		vSw <= '{16'h03E8, 16'h0005, 16'h0000};
		vCode <= 3'h4;
		host.drive(40, 0, 0);
		chk(0, 0, 40, 1);
		host.drive(240, 0, 0);
		chk(0, 1, 40, 0);
		chk(0, 0, 40, 0);
		$display("test conditions done");
		vCode <= 3'h0;
		host.drive(105, 0, 0);
		vSw <= '{16'h0003, 16'h0064, 16'h0014};
		vCode <= 3'h5;
		chk(0, 0, 8, 1);
		host.drive(111, 0, 0);
		chk(0, 1, 3, 0);
		host.drive(95, 0, 0);
		chk(0, 1, 20, 1);
		host.drive(89, 0, 0);
		chk(0, 1, 10, 1);
		chk(0, 0, 8, 0);
		$display("test hysteresis done");
		aMode <= 2'h1;
		pulse(1, 1);
		chk(3, {lastEst.res1Freq, lastEst.width3, lastEst.depth3}, 3, 0);
		chk(4, man4, 3, 0);
		pulse(0, 1);
		chk(3, {16'h1388, lastEst.width3, lastEst.depth3}, 3, 0);
		chk(5, 32'h1, 3, 0);
		aMode <= 2'h2;
		pulse(1, 1);
		chk(4, {lastEst.res2Freq, lastEst.width4, lastEst.depth4}, 3, 0);
		pulse(0, 0);
		chk(4, {nf(0, 0), lastEst.width4, lastEst.depth4}, 3, 0);
		chk(5, 32'h0, 3, 0);
		aMode <= 2'h0;
		pulse(1, 1);
		chk(3, man3, 3, 0);
		$display("test adaptive done");
		endOfTest();
	end
endmodule : test_sgs_gain_switch
